// ---- rtl/scrb_pkg.sv ----
// scrb_pkg: register map, field layout, reset values and timing of the sensor register bank.
// assumes a single core clock of 250 MHz; serial pins arrive asynchronous to it.
package scrb_pkg;
  // ----------------------------------------------------------------
  // register addresses (serial-bus 8-bit form; the 4-wire/3-wire form clears bit 7)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PART_IDENTIFIER = 8'hD1;
  localparam logic [7:0] ADDR_SOFT_RESET_TRIGGER = 8'hE0;
  localparam logic [7:0] ADDR_IIR_COEFFICIENT_SELECT = 8'hF1;
  localparam logic [7:0] ADDR_HS_MASTER_CODE_SELECT = 8'hF2;
  localparam logic [7:0] ADDR_DEVICE_CONDITION = 8'hF3;
  localparam logic [7:0] ADDR_MEASUREMENT_CONTROL = 8'hF4;
  localparam logic [7:0] ADDR_IO_CONFIGURATION = 8'hF5;
  localparam logic [7:0] SERIAL_ADDR_MASK = 8'h7F;
  localparam logic [7:0] ADDR_LAST = 8'hFF;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int STANDBY_LSB = 5;
  localparam int DRIVE_SEL_BIT = 2;
  localparam int THREE_WIRE_BIT = 0;
  localparam int TEMP_AVG_LSB = 5;
  localparam int PRESS_AVG_LSB = 2;
  localparam int POWER_MODE_LSB = 0;
  localparam int STAT_MEASURE_BIT = 3;
  localparam int STAT_OTP_BIT = 0;
  localparam int CODE_LSB = 0;
  // ----------------------------------------------------------------
  // reset values and constants
  // ----------------------------------------------------------------
  localparam logic [2:0] MASTER_CODE_RESET = 3'h1;
  localparam logic [7:0] MASTER_CODE_BASE = 8'h08;
  localparam logic [7:0] SOFT_RESET_KEY = 8'hE6;
  localparam logic [7:0] PART_IDENTIFIER_DEFAULT = 8'hA7; // arbitrary value
  localparam logic [1:0] PMODE_SLEEP = 2'h0;
  localparam logic [1:0] PMODE_NORMAL = 2'h3;
  localparam logic [2:0] IIR_MAX_CODE = 3'h5;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_KHZ = 250000;
  localparam int MS_TICK_CYCLES = CLK_FREQ_KHZ; // 1 ms in core cycles
  typedef enum logic [2:0] {
    ST_SLEEP = 3'b001,
    ST_MEAS = 3'b010,
    ST_WAIT = 3'b100
  } scrb_seq_e;
endpackage : scrb_pkg

// ---- rtl/scrb_register_bank.sv ----
// scrb_register_bank: control/status register bank with a 4-/3-wire serial slave front end,
// a measurement sequencer and the software reset.
// assumes the sensing core answers measDone and otpBusy on mclk; serial pins are asynchronous.
// Function
// RULE_01: register answers at address with bit7 cleared
// RULE_02: standby interval from io bits 7..5
// RULE_03: temperature and pressure averaging fields, 000 skips
// RULE_04: status bit3 high during measurement
// RULE_05: status bit0 high during calibration memory read
// RULE_06: status read-only, hardware updated, resets zero
// RULE_07: master code is 0x08 plus field
// RULE_08: filter field selects off or N 2..32
// RULE_09: any filter register write reinitialises filter
// RULE_10: key byte to reset register resets all
// RULE_11: other reset register bytes do nothing
// RULE_12: fixed read-only identification register
// RULE_13: host writes zero to reserved bits
// RULE_14: power mode sleep, forced, or normal
// RULE_15: io bit0 wire count, bit2 output type
`timescale 1ns/1ns
module scrb_register_bank #(
  parameter int TICKS_PER_MS = scrb_pkg::MS_TICK_CYCLES,
  parameter logic [7:0] PART_CODE = scrb_pkg::PART_IDENTIFIER_DEFAULT
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic chipSelect_n, // serial select, active low
  input wire logic serialClk, // serial clock from host
  input wire logic sdiIn, // data-in pin level
  output logic sdiOut, // data-in pin drive level (3-wire reads)
  output logic sdiOe_n, // data-in pin enable, low drives
  output logic sdoOut, // data-out pin level (4-wire reads)
  output logic sdoOe_n, // data-out pin enable, low drives
  input wire logic measDone, // core: result stored, one-cycle pulse
  input wire logic otpBusy, // core: calibration memory being read
  output logic measStart, // one-cycle pulse starting a measurement
  output logic [6:0] tempSamples, // averaging count, 0 skips
  output logic [6:0] pressSamples,
  output logic [2:0] iirStrength, // 0 off, else log2 N
  output logic iirInit, // one-cycle pulse clearing the filter
  output logic [7:0] hsMasterCode,
  output logic threeWire,
  output logic swReset // one-cycle pulse after the reset key
);
  import scrb_pkg::*;
  // the millisecond divider needs at least two cycles per tick
  if (TICKS_PER_MS < 2) begin : g_ticks_check
    $error("TICKS_PER_MS must be at least 2");
  end
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] csSync, sckSync, sdiSync; // [0] first stage, [1] second, [2] history
    logic [3:0] bitCnt; // bits of the current byte
    logic [7:0] shiftIn;
    logic [6:0] addr; // short-form address
    logic addrDone; // address byte received
    logic isRead;
    logic [7:0] shiftOut;
    logic outBit; // bit currently presented
    logic outActive;
    logic [2:0] standby;
    logic driveSel, wire3;
    logic [2:0] tempAvg, pressAvg;
    logic [1:0] pmode;
    logic [2:0] code, filt;
    logic measBusy, otpFlag;
    scrb_seq_e seq;
    logic [11:0] msLeft; // standby milliseconds left
    logic [31:0] tick; // cycles within one millisecond
    logic measStart, iirInit, swReset;
    logic [6:0] tempSamples, pressSamples;
    logic [2:0] iirStrength;
    logic [7:0] hsMasterCode;
    logic sdiOut, sdiOe_n, sdoOut, sdoOe_n;
  } scrb_state_s;
  localparam scrb_state_s RESET_STATE = '{
    code: MASTER_CODE_RESET, seq: ST_SLEEP, hsMasterCode: MASTER_CODE_BASE + 8'h01,
    sdiOe_n: 1'b1, sdoOe_n: 1'b1, csSync: 3'h7, default: '0};
  scrb_state_s cur, nxt;
  logic wrHit; // helper: a completed register write this cycle
  logic [7:0] wrAddr, wrData;
  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // long address matched against the short form
  function automatic logic hit(input logic [6:0] a, input logic [7:0] reg_addr);
    return {1'b0, a} == (reg_addr & SERIAL_ADDR_MASK); // RULE_01
  endfunction : hit
  // averaging code to sample count
  function automatic logic [6:0] samples(input logic [2:0] c);
    return (c == 3'h0) ? 7'h00 : 7'(7'h01 << (c - 3'h1)); // RULE_03
  endfunction : samples
  // standby code to milliseconds
  function automatic logic [11:0] standbyMs(input logic [2:0] c);
    case (c)
      3'h0: return 12'd1;
      3'h1: return 12'd5;
      3'h2: return 12'd50;
      3'h3: return 12'd250;
      3'h4: return 12'd500;
      3'h5: return 12'd1000;
      3'h6: return 12'd2000;
      default: return 12'd4000;
    endcase
  endfunction : standbyMs
  // register read mux; unmapped addresses read zero
  function automatic logic [7:0] readReg(input logic [6:0] a, input scrb_state_s s);
    logic [7:0] d;
    d = 8'h00;
    if (hit(a, ADDR_PART_IDENTIFIER)) d = PART_CODE; // RULE_12
    if (hit(a, ADDR_IIR_COEFFICIENT_SELECT)) d = {5'h00, s.filt};
    if (hit(a, ADDR_HS_MASTER_CODE_SELECT)) d = {5'h00, s.code};
    if (hit(a, ADDR_MEASUREMENT_CONTROL)) d = {s.tempAvg, s.pressAvg, s.pmode};
    if (hit(a, ADDR_IO_CONFIGURATION)) d = {s.standby, 2'b00, s.driveSel, 1'b0, s.wire3};
    if (hit(a, ADDR_DEVICE_CONDITION)) begin
      d[STAT_MEASURE_BIT] = s.measBusy; // RULE_04
      d[STAT_OTP_BIT] = s.otpFlag; // RULE_05
    end
    return d;
  endfunction : readReg
  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic sckRise, sckFall, csActive;
    logic [7:0] byteIn;
    csActive = !cur.csSync[1];
    sckRise = csActive && cur.sckSync[1] && !cur.sckSync[2];
    sckFall = csActive && !cur.sckSync[1] && cur.sckSync[2];
    byteIn = {cur.shiftIn[6:0], cur.sdiSync[1]};
    nxt = cur;
    nxt.measStart = 1'b0;
    nxt.iirInit = 1'b0;
    nxt.swReset = 1'b0;
    wrHit = 1'b0;
    wrAddr = 8'h00;
    wrData = 8'h00;
    // two-stage synchronisers; stage [0] feeds only stage [1], logic reads [1] and history
    nxt.csSync = {cur.csSync[1], cur.csSync[0], chipSelect_n};
    nxt.sckSync = {cur.sckSync[1], cur.sckSync[0], serialClk};
    nxt.sdiSync = {cur.sdiSync[1], cur.sdiSync[0], sdiIn};
    // serial slave: deselect ends the frame
    if (!csActive) begin
      nxt.bitCnt = 4'h0;
      nxt.addrDone = 1'b0;
      nxt.outActive = 1'b0;
    end else if (sckRise) begin
      // data sampled on the rising edge
      nxt.shiftIn = byteIn;
      nxt.bitCnt = cur.bitCnt + 4'h1;
      if (cur.bitCnt == 4'h7) begin
        nxt.bitCnt = 4'h0;
        if (!cur.addrDone) begin
          // control bit high means read, then seven address bits
          nxt.addrDone = 1'b1;
          nxt.isRead = byteIn[7];
          nxt.addr = byteIn[6:0];
          nxt.shiftOut = readReg(byteIn[6:0], cur);
        end else if (cur.isRead) begin
          // stream on; the last address repeats instead of wrapping
          if ({1'b1, cur.addr} != ADDR_LAST) nxt.addr = cur.addr + 7'h01;
          nxt.shiftOut = readReg(nxt.addr, cur);
        end else begin
          // write pairs address and data, then expects a new address
          wrHit = 1'b1;
          wrAddr = {1'b1, cur.addr};
          wrData = byteIn;
          nxt.addrDone = 1'b0;
        end
      end
    end else if (sckFall && cur.addrDone && cur.isRead) begin
      // output changes on the falling edge, half a bit ahead of the host sample
      nxt.outBit = cur.shiftOut[7];
      nxt.shiftOut = {cur.shiftOut[6:0], 1'b0};
      nxt.outActive = 1'b1;
    end
    // register writes; reserved bits are not stored, so they read zero
    if (wrHit) begin
      if (hit(cur.addr, ADDR_IO_CONFIGURATION)) begin
        nxt.standby = wrData[STANDBY_LSB +: 3]; // RULE_02
        nxt.driveSel = wrData[DRIVE_SEL_BIT]; // RULE_15
        nxt.wire3 = wrData[THREE_WIRE_BIT]; // RULE_15
      end
      if (hit(cur.addr, ADDR_MEASUREMENT_CONTROL)) begin
        nxt.tempAvg = wrData[TEMP_AVG_LSB +: 3]; // RULE_03
        nxt.pressAvg = wrData[PRESS_AVG_LSB +: 3]; // RULE_03
        nxt.pmode = wrData[POWER_MODE_LSB +: 2]; // RULE_14
      end
      if (hit(cur.addr, ADDR_HS_MASTER_CODE_SELECT)) nxt.code = wrData[CODE_LSB +: 3]; // RULE_07
      if (hit(cur.addr, ADDR_IIR_COEFFICIENT_SELECT)) begin
        nxt.filt = wrData[CODE_LSB +: 3]; // RULE_08
        nxt.iirInit = 1'b1; // RULE_09
      end
    end
    // status flags follow the core and the sequencer; no register write reaches them except the reset key
    nxt.otpFlag = otpBusy; // RULE_05 RULE_06
    // measurement sequencer
    unique case (cur.seq)
      ST_SLEEP: begin
        if (cur.pmode != PMODE_SLEEP) begin // RULE_14
          nxt.seq = ST_MEAS;
          nxt.measStart = 1'b1;
          nxt.measBusy = 1'b1; // RULE_04
        end
      end
      ST_MEAS: begin
        if (measDone) begin
          nxt.measBusy = 1'b0; // RULE_04
          if (cur.pmode == PMODE_NORMAL) begin
            nxt.seq = ST_WAIT;
            nxt.msLeft = standbyMs(cur.standby); // RULE_02
            nxt.tick = 32'h0;
          end else begin
            // a forced measurement falls back to sleep
            nxt.seq = ST_SLEEP;
            nxt.pmode = PMODE_SLEEP;
          end
        end
      end
      ST_WAIT: begin
        if (cur.pmode != PMODE_NORMAL) begin
          nxt.seq = ST_SLEEP;
        end else if (cur.tick == 32'(TICKS_PER_MS - 1)) begin
          nxt.tick = 32'h0;
          nxt.msLeft = cur.msLeft - 12'h001;
          if (cur.msLeft == 12'h001) begin
            nxt.seq = ST_MEAS;
            nxt.measStart = 1'b1;
            nxt.measBusy = 1'b1;
          end
        end else begin
          nxt.tick = cur.tick + 32'h1;
        end
      end
    endcase
    // software reset: key returns every register and the sequencer to reset
    // any other byte falls through and leaves every register alone
    if (wrHit && hit(cur.addr, ADDR_SOFT_RESET_TRIGGER)
        && wrData == SOFT_RESET_KEY) begin // RULE_10 RULE_11
      nxt = RESET_STATE; // RULE_10
      nxt.csSync = {cur.csSync[1], cur.csSync[0], chipSelect_n};
      nxt.sckSync = {cur.sckSync[1], cur.sckSync[0], serialClk};
      nxt.sdiSync = {cur.sdiSync[1], cur.sdiSync[0], sdiIn};
      nxt.swReset = 1'b1;
    end
    // registered decodes for the core
    nxt.tempSamples = samples(nxt.tempAvg);
    nxt.pressSamples = samples(nxt.pressAvg);
    nxt.iirStrength = (nxt.filt > IIR_MAX_CODE) ? IIR_MAX_CODE : nxt.filt; // RULE_08
    nxt.hsMasterCode = MASTER_CODE_BASE + {5'h00, nxt.code}; // RULE_07
    // pin drivers: 4-wire uses the data-out pin, 3-wire turns the data-in pin around
    nxt.sdoOut = nxt.outBit;
    nxt.sdiOut = nxt.outBit;
    nxt.sdoOe_n = !(nxt.outActive && !nxt.wire3); // RULE_15
    // open-drain style drives only a low level unless push-pull is chosen
    nxt.sdiOe_n = !(nxt.outActive && nxt.wire3 && (nxt.driveSel || !nxt.outBit)); // RULE_15
  end
  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cur <= RESET_STATE; // RULE_06
    end else begin
      cur <= nxt;
    end
  end
  assign sdiOut = cur.sdiOut;
  assign sdiOe_n = cur.sdiOe_n;
  assign sdoOut = cur.sdoOut;
  assign sdoOe_n = cur.sdoOe_n;
  assign measStart = cur.measStart;
  assign tempSamples = cur.tempSamples;
  assign pressSamples = cur.pressSamples;
  assign iirStrength = cur.iirStrength;
  assign iirInit = cur.iirInit;
  assign hsMasterCode = cur.hsMasterCode;
  assign threeWire = cur.wire3;
  assign swReset = cur.swReset;
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  AST_IIR_INIT: assert property (iirInit |-> $past(wrHit && hit(cur.addr,
    ADDR_IIR_COEFFICIENT_SELECT))) else $error("filter init without write"); // RULE_09
  AST_KEY_RESET: assert property (wrHit && wrAddr == ADDR_SOFT_RESET_TRIGGER &&
    wrData == SOFT_RESET_KEY |=> swReset && cur.pmode == 2'h0 && cur.code == 3'h1)
    else $error("key did not reset"); // RULE_10
  AST_OTHER_BYTE: assert property (wrHit && wrAddr == ADDR_SOFT_RESET_TRIGGER &&
    wrData != SOFT_RESET_KEY |=> !swReset && $stable(cur.code) && $stable(cur.filt))
    else $error("non-key byte changed state"); // RULE_11
  AST_MEAS_FLAG: assert property (measStart |-> cur.measBusy && cur.seq == ST_MEAS) // RULE_04
    else $error("measure flag low at start");
  AST_MEAS_DONE: assert property (cur.seq == ST_MEAS && measDone |=> !cur.measBusy)
    else $error("measure flag stuck after done"); // RULE_04
  AST_OTP_FLAG: assert property (##1 cur.otpFlag == $past(otpBusy))
    else $error("otp flag does not follow core"); // RULE_05
  AST_STATUS_RO: assert property (wrHit && wrAddr == ADDR_DEVICE_CONDITION |=> // RULE_06
    cur.measBusy == (cur.seq == ST_MEAS) && cur.otpFlag == $past(otpBusy))
    else $error("status written");
  AST_MASTER_CODE: assert property (##1 hsMasterCode == 8'h08 + {5'h00, $past(nxt.code)})
    else $error("master code wrong"); // RULE_07
  AST_FILTER_CAP: assert property (cur.filt >= 3'h5 |-> iirStrength == 3'h5)
    else $error("filter strength above 32"); // RULE_08
  AST_STANDBY: assert property (cur.seq == ST_WAIT |-> cur.msLeft <= 12'd4000)
    else $error("standby beyond 4 s"); // RULE_02
  AST_SKIP: assert property (cur.tempAvg == 3'h0 |-> tempSamples == 7'h00)
    else $error("skip code still averages"); // RULE_03
  AST_WIRE_MODE: assert property (cur.wire3 |-> sdoOe_n) else $error("4-wire pin in 3-wire"); // RULE_15
  AST_FORCED: assert property (cur.seq == ST_MEAS && measDone && cur.pmode != PMODE_NORMAL
    |=> cur.seq == ST_SLEEP) else $error("forced mode repeats"); // RULE_14
  AST_SHORT_ADDR: assert property (wrHit && wrAddr == ADDR_HS_MASTER_CODE_SELECT |=> // RULE_01
    cur.code == $past(wrData[2:0])) else $error("short address missed register");
  COV_MEAS: cover property (measStart ##[1:400] measDone);
  COV_IIR: cover property (iirInit);
  COV_RESET: cover property (swReset);
  COV_READ: cover property (!sdoOe_n ##1 !sdoOe_n);
endmodule : scrb_register_bank

// ---- verification/scrb_spi_host.sv ----
// scrb_spi_host: host end of the 4-/3-wire serial link, mode 0, MSB first.
// assumes the bench resolves both data pins with pull-ups and calls access() after reset.
`timescale 1ns/1ns
module scrb_spi_host (
  input wire logic mclk,
  input wire logic threeWireRead, // read data returns on the data-in pin
  input wire logic sdoPin,
  input wire logic sdiPin,
  output logic chipSelect_n,
  output logic serialClk,
  output logic hostBit,
  output logic hostOe_n // low while the host drives the data-in pin
);
  // ----------------------------------------------------------------
  // idle: deselected, clock parked low, data-in released
  // ----------------------------------------------------------------
  initial begin
    chipSelect_n = 1'b1;
    serialClk = 1'b0;
    hostBit = 1'b0;
    hostOe_n = 1'b1;
  end
  // one bit: 16 ns low then 16 ns high, above the 3-cycle minimum phase
  task automatic shift_bit(input logic o, output logic i);
    @(posedge mclk);
    serialClk <= 1'b0;
    hostBit <= o;
    repeat (4) @(posedge mclk);
    // sampled late in the low phase: the device answers 3 cycles after the fall
    i = threeWireRead ? sdiPin : sdoPin;
    serialClk <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask : shift_bit
  // one frame: header {rd, 7-bit address}, then one whole data byte
  task automatic access(input logic rd, input logic [6:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata);
    logic [7:0] hdr;
    logic unused;
    hdr = {rd, addr};
    @(posedge mclk);
    chipSelect_n <= 1'b0;
    hostOe_n <= 1'b0;
    repeat (4) @(posedge mclk);
    for (int k = 7; k >= 0; k--) shift_bit(hdr[k], unused);
    // a read hands the data-in pin over before the first data fall
    hostOe_n <= rd;
    for (int k = 7; k >= 0; k--) shift_bit(wdata[k], rdata[k]);
    @(posedge mclk);
    serialClk <= 1'b0;
    repeat (4) @(posedge mclk);
    chipSelect_n <= 1'b1;
    hostOe_n <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask : access
endmodule : scrb_spi_host

// ---- verification/scrb_register_bank_tb.sv ----
// scrb_register_bank_tb: register map, fields, measurement sequencing and soft reset.
// assumes a behavioural sensing core here and the serial host model beside it.
`timescale 1ns/1ns
module scrb_register_bank_tb;
  import scrb_pkg::*;
  localparam int TICKS = 4; // 1 ms shrunk to 4 cycles
  localparam logic [7:0] CODE = 8'h3A; // arbitrary part code
  localparam int MEAS_LAT = 300; // core conversion time in cycles
  logic mclk, reset_n, measDone, otpBusy, threeWireMode;
  logic chipSelect_n, serialClk, hostBit, hostOe_n;
  logic sdiOut, sdiOe_n, sdoOut, sdoOe_n, measStart, iirInit, threeWire, swReset;
  logic [6:0] tempSamples, pressSamples;
  logic [2:0] iirStrength;
  logic [7:0] hsMasterCode, rdata;
  int miscompares = 0, n_compared = 0, cyc = 0, nStarts = 0, nInit = 0, nSw = 0;
  int doneCyc = 0, lastGap = 0, measWait = 0, s0 = 0;
  wire logic sdoPin = sdoOe_n ? 1'b1 : sdoOut; // pull-up when released
  wire logic sdiPin = !sdiOe_n ? sdiOut : (!hostOe_n ? hostBit : 1'b1);
  scrb_register_bank #(.TICKS_PER_MS(TICKS), .PART_CODE(CODE)) i_dut (.mclk(mclk),
    .reset_n(reset_n), .chipSelect_n(chipSelect_n), .serialClk(serialClk), .sdiIn(sdiPin),
    .sdiOut(sdiOut), .sdiOe_n(sdiOe_n), .sdoOut(sdoOut), .sdoOe_n(sdoOe_n),
    .measDone(measDone), .otpBusy(otpBusy), .measStart(measStart),
    .tempSamples(tempSamples), .pressSamples(pressSamples), .iirStrength(iirStrength),
    .iirInit(iirInit), .hsMasterCode(hsMasterCode), .threeWire(threeWire), .swReset(swReset));
  scrb_spi_host i_host (.mclk(mclk), .threeWireRead(threeWireMode), .sdoPin(sdoPin),
    .sdiPin(sdiPin), .chipSelect_n(chipSelect_n), .serialClk(serialClk), .hostBit(hostBit),
    .hostOe_n(hostOe_n));
  // ----------------------------------------------------------------
  // clock, core model, pulse counters, timeout
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // core answers each start after a fixed latency; gaps show the standby wait
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    measDone <= 1'b0;
    if (measStart === 1'b1) begin
      measWait <= MEAS_LAT;
      nStarts <= nStarts + 1;
      lastGap <= cyc - doneCyc;
    end else if (measWait == 1) begin
      measDone <= 1'b1;
      doneCyc <= cyc;
      measWait <= 0;
    end else if (measWait > 1) begin
      measWait <= measWait - 1;
    end
    if (iirInit === 1'b1) nInit <= nInit + 1;
    if (swReset === 1'b1) nSw <= nSw + 1;
    // the whole run needs roughly 11000 cycles
    if (cyc == 30000) begin
      miscompares++;
      close_out();
    end
  end
  // ----------------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] unused;
    i_host.access(1'b0, addr[6:0], data, unused);
  endtask : wr
  task automatic rdc(input logic [7:0] addr, input logic [7:0] exp, input string what);
    i_host.access(1'b1, addr[6:0], 8'h00, rdata);
    check(what, rdata, exp);
  endtask : rdc
  task automatic close_out();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    otpBusy = 1'b0;
    threeWireMode = 1'b0;
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    rdc(ADDR_HS_MASTER_CODE_SELECT, 8'h01, "master code reset");
    check("master code out", hsMasterCode, 8'h09);
    rdc(ADDR_IIR_COEFFICIENT_SELECT, 8'h00, "filter reset");
    rdc(ADDR_DEVICE_CONDITION, 8'h00, "status reset");
    rdc(ADDR_MEASUREMENT_CONTROL, 8'h00, "control reset");
    rdc(ADDR_IO_CONFIGURATION, 8'h00, "io reset");
    check("three wire reset", {7'h00, threeWire}, 8'h00);
    rdc(ADDR_PART_IDENTIFIER, CODE, "part code");
    wr(ADDR_PART_IDENTIFIER, 8'h00);
    rdc(ADDR_PART_IDENTIFIER, CODE, "part code after write");
    wr(ADDR_DEVICE_CONDITION, 8'h09);
    rdc(ADDR_DEVICE_CONDITION, 8'h00, "status after write");
    rdc(8'h10, 8'h00, "unmapped read");
    $display("test reset values done");
    for (int n = 0; n < 8; n++) begin
      wr(ADDR_HS_MASTER_CODE_SELECT, {5'h00, 3'(n)});
      check("master code", hsMasterCode, MASTER_CODE_BASE + 8'(n));
      rdc(ADDR_HS_MASTER_CODE_SELECT, {5'h00, 3'(n)}, "master code back");
    end
    s0 = nInit;
    for (int n = 0; n < 8; n++) begin
      wr(ADDR_IIR_COEFFICIENT_SELECT, {5'h00, 3'(n)});
      check("filter strength", {5'h00, iirStrength}, (n > 5) ? 8'h05 : 8'(n));
    end
    check("filter inits", 8'(nInit - s0), 8'h08);
    for (int t = 0; t < 8; t++) begin
      wr(ADDR_MEASUREMENT_CONTROL, {3'(t), 3'(7 - t), 2'b00});
      check("temp samples", {1'b0, tempSamples}, (t == 0) ? 8'h00 : 8'h01 << (t - 1));
      check("press samples", {1'b0, pressSamples}, (t == 7) ? 8'h00 : 8'h01 << (6 - t));
    end
    $display("test fields done");
    s0 = nStarts;
    wr(ADDR_MEASUREMENT_CONTROL, 8'h25);
    rdc(ADDR_DEVICE_CONDITION, 8'h08, "measuring flag");
    repeat (MEAS_LAT) @(posedge mclk);
    rdc(ADDR_DEVICE_CONDITION, 8'h00, "flag after store");
    rdc(ADDR_MEASUREMENT_CONTROL, 8'h24, "forced returns to sleep");
    check("forced starts", 8'(nStarts - s0), 8'h01);
    otpBusy <= 1'b1;
    repeat (4) @(posedge mclk);
    rdc(ADDR_DEVICE_CONDITION, 8'h01, "calibration read flag");
    otpBusy <= 1'b0;
    repeat (4) @(posedge mclk);
    rdc(ADDR_DEVICE_CONDITION, 8'h00, "calibration idle");
    wr(ADDR_IO_CONFIGURATION, 8'h40);
    s0 = nStarts;
    wr(ADDR_MEASUREMENT_CONTROL, 8'h27);
    repeat (1200) @(posedge mclk);
    check("normal repeats", 8'(nStarts - s0 >= 2), 8'h01);
    check("standby gap", 8'(lastGap >= 50 * TICKS && lastGap <= 50 * TICKS + 8), 8'h01);
    wr(ADDR_MEASUREMENT_CONTROL, 8'h24);
    repeat (MEAS_LAT + 50) @(posedge mclk);
    $display("test measurement done");
    wr(ADDR_SOFT_RESET_TRIGGER, 8'hAA);
    check("no reset pulse", 8'(nSw), 8'h00);
    rdc(ADDR_HS_MASTER_CODE_SELECT, 8'h07, "code kept");
    wr(ADDR_SOFT_RESET_TRIGGER, SOFT_RESET_KEY);
    check("reset pulse", 8'(nSw), 8'h01);
    check("master code out", hsMasterCode, 8'h09);
    rdc(ADDR_HS_MASTER_CODE_SELECT, 8'h01, "code restored");
    rdc(ADDR_IO_CONFIGURATION, 8'h00, "io restored");
    $display("test soft reset done");
    wr(ADDR_IO_CONFIGURATION, 8'h01);
    threeWireMode <= 1'b1;
    check("three wire on", {7'h00, threeWire}, 8'h01);
    rdc(ADDR_PART_IDENTIFIER, CODE, "three wire read");
    wr(ADDR_IO_CONFIGURATION, 8'h05);
    rdc(ADDR_PART_IDENTIFIER, CODE, "push-pull read");
    wr(ADDR_IO_CONFIGURATION, 8'h00);
    threeWireMode <= 1'b0;
    rdc(ADDR_PART_IDENTIFIER, CODE, "four wire again");
    $display("test wire modes done");
    close_out();
  end
endmodule : scrb_register_bank_tb
